// ===== fbc_checker.v
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "fbc_map.vh"
module fbc_checker #(
    parameter SECOND_CYC = `FBC_SECOND_CYC
) (
    input  wire        CLK_SYS,
    input  wire        RESET,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire [1:0]  TX_READY,
    output reg  [63:0] TX_DATA,
    output reg  [1:0]  TX_VALID,
    input  wire [63:0] RX_DATA,
    input  wire [1:0]  RX_VALID,
    input  wire [1:0]  RX_FILTER1,
    input  wire [1:0]  RX_CSUM_OK,
    input  wire [1:0]  RX_FRAME_START,
    output reg  [1:0]  CSUM_ERR,
    output reg  [1:0]  LOST_FRAME,
    output reg  [1:0]  PATTERN_SYNC_LOSS,
    output reg         IRQ
);
    reg  [31:0] ctrl_q;
    reg  [31:0] user_q [0:1];
    reg  [3:0]  int_stat_q;
    reg  [3:0]  int_mask_q;
    reg  [31:0] err_q [0:1];
    reg  [31:0] bits_q [0:1];
    reg  [31:0] err_sec_q [0:1];
    reg  [31:0] sec_cnt_q;
    reg         run_q;
    wire        sec_tick = (sec_cnt_q == SECOND_CYC - 1);
    wire        start = ctrl_q[`FBC_CTRL_RUN] & ~run_q;
    wire        acc = PSEL & PENABLE;
    wire        wr = acc & PWRITE;
    wire [1:0]  ev;

    // Population count of a 32-bit mismatch word
    function [5:0] popcnt;
        input [31:0] v;
        integer i;
        begin
            popcnt = 6'h00;
            for (i = 0; i < 32; i = i + 1)
                popcnt = popcnt + {5'h00, v[i]};
        end
    endfunction

    // Next pattern word for a selection
    function [31:0] pat_word;
        input [1:0]  sel;
        input [31:0] user;
        input [14:0] lfsr;
        begin
            case (sel)
                `FBC_PAT_PRBS15: pat_word = {lfsr, lfsr[14:0] ^ {lfsr[13:0], lfsr[14]}, 2'h0};
                `FBC_PAT_ALT:    pat_word = 32'haaaa_aaaa;
                `FBC_PAT_ZERO:   pat_word = 32'h0000_0000;
                default:         pat_word = user;
            endcase
        end
    endfunction

    function [14:0] lfsr_step;
        input [14:0] s;
        begin
            lfsr_step = {s[13:0], s[14] ^ s[13]};
        end
    endfunction

    // Offsets that take a write without error
    function wr_ok;
        input [11:0] a;
        begin
            case (a)
                `FBC_OFF_CTRL, `FBC_OFF_USER0, `FBC_OFF_USER1,
                `FBC_OFF_INT_MASK, `FBC_OFF_STATUS: wr_ok = 1'b1;
                default:                            wr_ok = 1'b0;
            endcase
        end
    endfunction

    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            run_q     <= 1'b0;
            sec_cnt_q <= 32'h0000_0000;
        end else begin
            run_q     <= ctrl_q[`FBC_CTRL_RUN];
            if (start || sec_tick || !run_q)
                sec_cnt_q <= 32'h0000_0000;
            else
                sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
        end
    end

    // One generator/analyser pair per port
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            wire [1:0]  sel = ctrl_q[`FBC_CTRL_SEL0_LO + 2*p +: 2];
            wire        en = run_q & ctrl_q[`FBC_CTRL_EP0 + p]
                             & ctrl_q[`FBC_CTRL_PAY0 + p];
            reg  [14:0] tx_lfsr_q;
            reg  [14:0] rx_lfsr_q;
            reg         loss_q;
            reg  [3:0]  good_q;
            reg         sec_bad_q;
            wire [31:0] exp_w = pat_word(sel, user_q[p], rx_lfsr_q);
            // Filter 1 traffic only, valid checksums only
            wire        take = en & RX_VALID[p] & RX_FILTER1[p] & RX_CSUM_OK[p];
            wire        bad_cs = en & RX_VALID[p] & RX_FILTER1[p] & ~RX_CSUM_OK[p];
            wire [31:0] diff = RX_DATA[32*p +: 32] ^ exp_w;
            wire [5:0]  nerr = popcnt(diff);
            wire        hit = take & (diff != 32'h0000_0000);
            assign ev[p] = hit & ~loss_q;
            always @(posedge CLK_SYS or posedge RESET) begin
                if (RESET) begin
                    tx_lfsr_q       <= `FBC_PRBS_SEED;
                    rx_lfsr_q       <= `FBC_PRBS_SEED;
                    loss_q          <= 1'b0;
                    good_q          <= 4'h0;
                    sec_bad_q       <= 1'b0;
                    err_q[p]        <= 32'h0000_0000;
                    bits_q[p]       <= 32'h0000_0000;
                    err_sec_q[p]    <= 32'h0000_0000;
                    TX_DATA[32*p +: 32] <= 32'h0000_0000;
                    TX_VALID[p]     <= 1'b0;
                    CSUM_ERR[p]     <= 1'b0;
                    LOST_FRAME[p]   <= 1'b0;
                    PATTERN_SYNC_LOSS[p] <= 1'b0;
                end else if (start) begin
                    tx_lfsr_q       <= `FBC_PRBS_SEED;
                    rx_lfsr_q       <= `FBC_PRBS_SEED;
                    loss_q          <= 1'b0;
                    good_q          <= 4'h0;
                    sec_bad_q       <= 1'b0;
                    err_q[p]        <= 32'h0000_0000;
                    bits_q[p]       <= 32'h0000_0000;
                    err_sec_q[p]    <= 32'h0000_0000;
                    TX_VALID[p]     <= 1'b0;
                    CSUM_ERR[p]     <= 1'b0;
                    LOST_FRAME[p]   <= 1'b0;
                    PATTERN_SYNC_LOSS[p] <= 1'b0;
                end else begin
                    // Generator on flow 1
                    TX_VALID[p] <= en;
                    if (en && (TX_READY[p] || !TX_VALID[p])) begin
                        TX_DATA[32*p +: 32] <= pat_word(sel, user_q[p], tx_lfsr_q);
                        tx_lfsr_q <= lfsr_step(tx_lfsr_q);
                        bits_q[p] <= bits_q[p] + 32'h0000_0020;
                    end
                    // Bad checksum: no compare, report as checksum error and loss
                    CSUM_ERR[p]   <= bad_cs;
                    LOST_FRAME[p] <= bad_cs;
                    if (take) begin
                        // Frame start during sync loss resyncs the PRBS reference to tolerate lost frames
                        if (RX_FRAME_START[p] && loss_q)
                            rx_lfsr_q <= lfsr_step(RX_DATA[32*p+17 +: 15]);
                        else
                            rx_lfsr_q <= lfsr_step(rx_lfsr_q);
                        if (hit) begin
                            good_q <= 4'h0;
                            loss_q <= 1'b1;
                        end else if (loss_q) begin
                            good_q <= good_q + 4'h1;
                            if (good_q + 4'h1 >= `FBC_SYNC_GOOD)
                                loss_q <= 1'b0;
                        end
                        if (ev[p])
                            err_q[p] <= err_q[p] + {26'h0, nerr};
                    end
                    PATTERN_SYNC_LOSS[p] <= loss_q;
                    if (sec_tick) begin
                        if (sec_bad_q || hit || loss_q)
                            err_sec_q[p] <= err_sec_q[p] + 32'h0000_0001;
                        sec_bad_q <= 1'b0;
                    end else if (hit || loss_q) begin
                        sec_bad_q <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // APB slave, zero wait states; results readable anytime
    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ctrl_q     <= `FBC_CTRL_RST;
            user_q[0]  <= `FBC_USER_RST;
            user_q[1]  <= `FBC_USER_RST;
            int_mask_q <= 4'h0;
            int_stat_q <= 4'h0;
            PRDATA     <= 32'h0000_0000;
            PREADY     <= 1'b0;
            PSLVERR    <= 1'b0;
            IRQ        <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            // Error rides with ready so the master sees it in the access phase
            PSLVERR <= PSEL & ~PENABLE & PWRITE & ~wr_ok(PADDR);
            // Event set wins over read clear; only reported bits clear
            if (acc && PREADY && !PWRITE && PADDR == `FBC_OFF_INT_STAT)
                int_stat_q <= (int_stat_q & ~PRDATA[3:0])
                              | {run_q & |PATTERN_SYNC_LOSS, 1'b0, ev[1:0]};
            else
                int_stat_q <= int_stat_q | {run_q & |PATTERN_SYNC_LOSS, 1'b0, ev[1:0]};
            IRQ <= |(int_stat_q & int_mask_q);
            if (wr && PREADY) begin
                case (PADDR)
                    `FBC_OFF_CTRL:     ctrl_q     <= PWDATA;
                    `FBC_OFF_USER0:    user_q[0]  <= PWDATA;
                    `FBC_OFF_USER1:    user_q[1]  <= PWDATA;
                    `FBC_OFF_INT_MASK: int_mask_q <= PWDATA[3:0];
                    default:           ;
                endcase
            end
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `FBC_OFF_CTRL:     PRDATA <= ctrl_q;
                    `FBC_OFF_USER0:    PRDATA <= user_q[0];
                    `FBC_OFF_USER1:    PRDATA <= user_q[1];
                    `FBC_OFF_STATUS:   PRDATA <= {29'h0, PATTERN_SYNC_LOSS, run_q};
                    `FBC_OFF_INT_STAT: PRDATA <= {28'h0, int_stat_q};
                    `FBC_OFF_INT_MASK: PRDATA <= {28'h0, int_mask_q};
                    `FBC_OFF_ERR0:     PRDATA <= err_q[0];
                    `FBC_OFF_BITS0:    PRDATA <= bits_q[0];
                    `FBC_OFF_ERRSEC0:  PRDATA <= err_sec_q[0];
                    `FBC_OFF_ERR1:     PRDATA <= err_q[1];
                    `FBC_OFF_BITS1:    PRDATA <= bits_q[1];
                    `FBC_OFF_ERRSEC1:  PRDATA <= err_sec_q[1];
                    default:           PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // fbc_checker

// ===== fbc_map.vh
`ifndef FBC_MAP_VH
`define FBC_MAP_VH
// APB register byte offsets
`define FBC_OFF_CTRL      12'h000
`define FBC_OFF_USER0     12'h004
`define FBC_OFF_USER1     12'h008
`define FBC_OFF_STATUS    12'h00c
`define FBC_OFF_INT_STAT  12'h010
`define FBC_OFF_INT_MASK  12'h014
`define FBC_OFF_ERR0      12'h020
`define FBC_OFF_BITS0     12'h024
`define FBC_OFF_ERRSEC0   12'h028
`define FBC_OFF_ERR1      12'h030
`define FBC_OFF_BITS1     12'h034
`define FBC_OFF_ERRSEC1   12'h038
// Control field positions
`define FBC_CTRL_RUN      0
`define FBC_CTRL_EP0      1
`define FBC_CTRL_EP1      2
`define FBC_CTRL_PAY0     3
`define FBC_CTRL_PAY1     4
`define FBC_CTRL_SEL0_LO  8
`define FBC_CTRL_SEL1_LO  10
// Pattern selections
`define FBC_PAT_PRBS15    2'h0
`define FBC_PAT_ALT       2'h1
`define FBC_PAT_ZERO      2'h2
`define FBC_PAT_USER      2'h3
// Reset values
`define FBC_CTRL_RST      32'h0000_0000
`define FBC_USER_RST      32'h0000_0000
`define FBC_PRBS_SEED     15'h7fff
// One second at 100 MHz
`define FBC_SECOND_NS     1000000000
`define FBC_CLK_NS        10
`define FBC_SECOND_CYC    (`FBC_SECOND_NS / `FBC_CLK_NS)
// Sync: this many clean words regain alignment
`define FBC_SYNC_GOOD     4'h4
`endif

// ===== fbc_checker_props.sv
`timescale 1ns/1ps
module fbc_checker_props (
    input wire        CLK_SYS,
    input wire        RESET,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire [1:0]  TX_READY,
    input wire [63:0] TX_DATA,
    input wire [1:0]  TX_VALID,
    input wire [1:0]  RX_VALID,
    input wire [1:0]  RX_FILTER1,
    input wire [1:0]  RX_CSUM_OK,
    input wire [1:0]  CSUM_ERR,
    input wire [1:0]  LOST_FRAME,
    input wire [1:0]  PATTERN_SYNC_LOSS
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    wire [1:0] cmp = RX_VALID & RX_FILTER1 & RX_CSUM_OK;
    wire [1:0] bad = RX_VALID & ~RX_CSUM_OK;
    wire [1:0] psl = PATTERN_SYNC_LOSS;
    wire       wr_done = PSEL & PENABLE & PREADY & PWRITE;
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_done;
        PSEL && PENABLE && PREADY;
    endsequence
    a_apb_ready: assert property (s_setup |=> s_done)
        else $error("no ready after setup");
    a_err_ready: assert property (PSLVERR |-> PREADY && PWRITE)
        else $error("slverr outside write");
    a_hole_zero: assert property (s_done ##0 (!PWRITE && PADDR >= 12'h040) |-> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_csum_lost: assert property (CSUM_ERR == LOST_FRAME)
        else $error("checksum and lost frame differ");
    a_csum_cause: assert property ((CSUM_ERR & ~$past(bad)) == 2'h0)
        else $error("checksum error without bad word");
    a_loss_cause: assert property ((psl & ~$past(psl) & ~$past(cmp, 2)) == 2'h0)
        else $error("sync loss without compared word");
    // A test restart may clear the flag without a word
    a_loss_clear: assert property ($past(wr_done, 3) || (~psl & $past(psl) & ~$past(cmp, 2)) == 2'h0)
        else $error("sync regained without word");
    a_tx_hold: assert property (TX_VALID[0] && !TX_READY[0] |=> $stable(TX_DATA[31:0]))
        else $error("pattern word moved while stalled");
endmodule // fbc_checker_props

bind fbc_checker fbc_checker_props u_props (.CLK_SYS, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PRDATA, .PREADY, .PSLVERR, .TX_READY, .TX_DATA, .TX_VALID, .RX_VALID, .RX_FILTER1,
    .RX_CSUM_OK, .CSUM_ERR, .LOST_FRAME, .PATTERN_SYNC_LOSS);

// ===== fbc_net.sv
`timescale 1ns/1ps
module fbc_net (
    input  wire        clk,
    input  wire [1:0]  stall,
    input  wire [1:0]  bad,
    input  wire [1:0]  filt,
    input  wire [63:0] flip,
    input  wire [63:0] tx_data,
    input  wire [1:0]  tx_valid,
    output wire [1:0]  tx_ready,
    output reg  [63:0] rx_data = 64'h0,
    output reg  [1:0]  rx_valid = 2'h0,
    output reg  [1:0]  rx_csum_ok = 2'h3,
    output reg  [1:0]  rx_filter1 = 2'h3,
    output wire [1:0]  rx_frame_start
);
    reg  [2:0] word_q = 3'h0;
    wire [1:0] take = tx_valid & tx_ready;
    assign tx_ready = ~stall;
    // Frame start every eight clock cycles, taken or not, both ports in step
    assign rx_frame_start = {2{word_q == 3'h0}};
    always @(posedge clk) begin
        rx_valid <= take;
        rx_csum_ok <= ~bad;
        // Filter tag travels with its word
        rx_filter1 <= filt;
        word_q <= word_q + 3'h1;
        // Idle lines toggle so a stale word never passes for data
        rx_data[31:0] <= take[0] ? tx_data[31:0] ^ flip[31:0] : ~rx_data[31:0];
        rx_data[63:32] <= take[1] ? tx_data[63:32] ^ flip[63:32] : ~rx_data[63:32];
    end
endmodule // fbc_net

// ===== test_framed_bert_checker.sv
`timescale 1ns/1ps
`include "fbc_map.vh"
module test_framed_bert_checker;
    reg         CLK_SYS = 1'b0;
    reg         RESET = 1'b1;
    reg         PSEL = 1'b0;
    reg         PENABLE = 1'b0;
    reg         PWRITE = 1'b0;
    reg  [11:0] PADDR = 12'h000;
    reg  [31:0] PWDATA = 32'h0;
    reg  [1:0]  STALL = 2'h0;
    reg  [1:0]  BAD = 2'h0;
    reg  [1:0]  FILT = 2'h3;
    reg  [63:0] FLIP = 64'h0;
    wire [63:0] TX_DATA, RX_DATA;
    wire [31:0] PRDATA;
    wire [1:0]  TX_READY, TX_VALID, RX_VALID, RX_FILTER1, RX_CSUM_OK, RX_FRAME_START;
    wire [1:0]  CSUM_ERR, LOST_FRAME, PSL;
    wire        PREADY, PSLVERR, IRQ;
    reg  [31:0] r, e;
    reg         slv;
    integer     mismatches = 0, num_checks = 0, n_csum = 0, n_lost = 0, s;
    reg  [31:0] want [0:3] = '{32'h1, 32'haaaaaaaa, 32'h0, 32'h1234abcd};
    fbc_checker #(.SECOND_CYC(100)) dut (.CLK_SYS, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .TX_READY, .TX_DATA, .TX_VALID, .RX_DATA,
        .RX_VALID, .RX_FILTER1, .RX_CSUM_OK, .RX_FRAME_START, .CSUM_ERR, .LOST_FRAME,
        .PATTERN_SYNC_LOSS(PSL), .IRQ);
    fbc_net net (.clk(CLK_SYS), .stall(STALL), .bad(BAD), .filt(FILT), .flip(FLIP),
        .tx_data(TX_DATA), .tx_valid(TX_VALID), .tx_ready(TX_READY), .rx_data(RX_DATA),
        .rx_valid(RX_VALID), .rx_csum_ok(RX_CSUM_OK), .rx_filter1(RX_FILTER1),
        .rx_frame_start(RX_FRAME_START));
    initial forever #5 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) if (!RESET) n_csum <= n_csum + CSUM_ERR[0];
    always @(posedge CLK_SYS) if (!RESET) n_lost <= n_lost + LOST_FRAME[0];
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("Error %s: expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task apb(input [11:0] a, input w, input [31:0] d);
        integer n;
        begin
            n = 0;
            PSEL <= 1'b1;
            PADDR <= a;
            PWRITE <= w;
            PWDATA <= d;
            @(posedge CLK_SYS);
            PENABLE <= 1'b1;
            do begin
                @(posedge CLK_SYS);
                n = n + 1;
            end while (PREADY !== 1'b1 && n < 20);
            r = PRDATA;
            slv = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
            if (n == 20) begin
                mismatches = mismatches + 1;
                end_sim;
            end
            @(posedge CLK_SYS);
        end
    endtask
    // One flipped word with the given checksum and filter state
    task hit(input [1:0] b, input [1:0] f, input [63:0] x);
        begin
            BAD <= b;
            FILT <= f;
            FLIP <= x;
            cyc(1);
            BAD <= 2'h0;
            FILT <= 2'h3;
            FLIP <= 64'h0;
            cyc(1);
        end
    endtask
    initial begin
        cyc(4);
        RESET <= 1'b0;
        apb(`FBC_OFF_CTRL, 0, 0);
        chk("ctrl", r, `FBC_CTRL_RST);
        apb(12'h100, 1, 1);
        chk("slverr", slv, 1);
        apb(12'h100, 0, 0);
        chk("hole", r, 0);
        apb(`FBC_OFF_USER0, 1, 32'h1234abcd);
        apb(`FBC_OFF_CTRL, 1, 32'hb1f);
        // Restart drops any word sent before the pattern settled
        apb(`FBC_OFF_CTRL, 1, 32'hb1e);
        apb(`FBC_OFF_CTRL, 1, 32'hb1f);
        cyc(10);
        chk("tx0", TX_DATA[31:0], 32'h1234abcd);
        chk("tx1", TX_DATA[63:32], 0);
        $display("setup test done");
        hit(2'h0, 2'h3, 64'h7);
        cyc(2);
        chk("loss", PSL, 1);
        cyc(20);
        chk("loss", PSL, 0);
        apb(`FBC_OFF_ERR0, 0, 0);
        chk("err0", r, 3);
        apb(`FBC_OFF_ERR1, 0, 0);
        chk("err1", r, 0);
        chk("irq", IRQ, 0);
        apb(`FBC_OFF_INT_MASK, 1, 1);
        cyc(2);
        chk("irq", IRQ, 1);
        apb(`FBC_OFF_INT_STAT, 0, 0);
        chk("stat", r[0], 1);
        cyc(2);
        chk("irq", IRQ, 0);
        cyc(100);
        apb(`FBC_OFF_ERRSEC0, 0, 0);
        chk("errsec0", r != 0, 1);
        apb(`FBC_OFF_ERRSEC1, 0, 0);
        chk("errsec1", r, 0);
        $display("error test done");
        hit(2'h1, 2'h3, 64'hff);
        hit(2'h0, 2'h2, 64'hff);
        STALL <= 2'h1;
        cyc(6);
        STALL <= 2'h0;
        cyc(20);
        chk("csum", n_csum, 1);
        chk("lost", n_lost, 1);
        chk("loss", PSL, 0);
        apb(`FBC_OFF_ERR0, 0, 0);
        chk("err0", r, 3);
        apb(`FBC_OFF_BITS0, 0, 0);
        chk("bits", {r[4:0], r != 0}, 6'h01);
        apb(`FBC_OFF_CTRL, 1, 32'hb1d);
        cyc(3);
        chk("txv", TX_VALID, 2'h2);
        apb(`FBC_OFF_ERR0, 0, 0);
        chk("err0", r, 3);
        apb(`FBC_OFF_CTRL, 1, 32'hb1e);
        apb(`FBC_OFF_CTRL, 1, 32'hb1f);
        apb(`FBC_OFF_ERR0, 0, 0);
        chk("err0", r, 0);
        apb(`FBC_OFF_ERRSEC0, 0, 0);
        chk("errsec0", r, 0);
        $display("filter test done");
        for (s = 0; s < 4; s = s + 1) begin
            apb(`FBC_OFF_CTRL, 1, 32'h81f | (s << 8));
            cyc(4);
            // Stalled sink must see the same word until it takes it
            STALL <= 2'h1;
            cyc(1);
            e = TX_DATA[31:0];
            cyc(2);
            chk("hold", TX_DATA[31:0], e);
            STALL <= 2'h0;
            cyc(1);
            e = TX_DATA[31:0];
            cyc(1);
            r = (s == 0) ? {31'h0, e != TX_DATA[31:0]} : e;
            chk("pat", r, want[s]);
        end
        $display("pattern test done");
        end_sim;
    end
endmodule // test_framed_bert_checker
